// ---- verilog/dprcm_map.vh ----
// constants for the dual-port ram clock-mode block
`ifndef DPRCM_MAP_VH
`define DPRCM_MAP_VH
`define DPRCM_AW          8
`define DPRCM_DW          16
`define DPRCM_BW          2
`define DPRCM_LANE        8
`define DPRCM_DEPTH       256
`define DPRCM_NPIN        4
`define DPRCM_MODE_INDEP  2'h0
`define DPRCM_MODE_IOCLK  2'h1
`define DPRCM_MODE_RWCLK  2'h2
`define DPRCM_MODE_SINGLE 2'h3
`define DPRCM_ADDR_CLR    8'h00
`define DPRCM_DATA_CLR    16'h0000
`define DPRCM_BE_CLR      2'h0
`define DPRCM_BIT_CLR     1'h0
`define DPRCM_BIT_SET     1'h1
`define DPRCM_REL_CLR     2'h0
`endif

// ---- verilog/dprcm_mem.v ----
// storage array of the medium ram block, two ports, registered reads
`timescale 1ns/1ps
`default_nettype none
`include "dprcm_map.vh"
module dprcm_mem (
  input  wire                    mclk,
  input  wire                    weA,
  input  wire [`DPRCM_BW-1:0]    beA,
  input  wire [`DPRCM_AW-1:0]    addrA,
  input  wire [`DPRCM_DW-1:0]    wdA,
  output reg  [`DPRCM_DW-1:0]    rdA,
  input  wire                    weB,
  input  wire [`DPRCM_BW-1:0]    beB,
  input  wire [`DPRCM_AW-1:0]    addrB,
  input  wire [`DPRCM_DW-1:0]    wdB,
  output reg  [`DPRCM_DW-1:0]    rdB
);
  reg [`DPRCM_DW-1:0] mem [0:`DPRCM_DEPTH-1];
  integer i;

  // read-before-write; on a same-address collision port b lands last
  always @(posedge mclk) begin
    for (i = 0; i < `DPRCM_BW; i = i + 1) begin
      if (weA && beA[i]) begin
        mem[addrA][i*`DPRCM_LANE +: `DPRCM_LANE] <=
          wdA[i*`DPRCM_LANE +: `DPRCM_LANE];
      end
      if (weB && beB[i]) begin
        mem[addrB][i*`DPRCM_LANE +: `DPRCM_LANE] <=
          wdB[i*`DPRCM_LANE +: `DPRCM_LANE];
      end
    end
    rdA <= mem[addrA];
    rdB <= mem[addrB];
  end
endmodule
`default_nettype wire

// ---- verilog/dprcm_core.v ----
// clock-mode and port-mode logic around the medium ram block
`timescale 1ns/1ps
`default_nettype none
`include "dprcm_map.vh"
module dprcm_core (
  input  wire                    mclk,
  input  wire                    reset_n,
  input  wire [1:0]              mode,
  input  wire                    simpleDual,
  input  wire                    splitSingle,
  input  wire                    clkA,
  input  wire                    clkOutA,
  input  wire                    ceInA,
  input  wire                    ceOutA,
  input  wire                    clrInA,
  input  wire                    clrOutA,
  input  wire [`DPRCM_AW-1:0]    addrA,
  input  wire [`DPRCM_DW-1:0]    dataInA,
  input  wire                    wrenA,
  input  wire [`DPRCM_BW-1:0]    byteEnA,
  output wire [`DPRCM_DW-1:0]    dataOutA,
  input  wire                    clkB,
  input  wire                    clkOutB,
  input  wire                    ceInB,
  input  wire                    ceOutB,
  input  wire                    clrInB,
  input  wire                    clrOutB,
  input  wire [`DPRCM_AW-1:0]    addrB,
  input  wire [`DPRCM_DW-1:0]    dataInB,
  input  wire                    wrenB,
  input  wire [`DPRCM_BW-1:0]    byteEnB,
  input  wire                    rdenB,
  output wire [`DPRCM_DW-1:0]    dataOutB
);
  wire [`DPRCM_NPIN-1:0]   clkPins;
  wire [`DPRCM_NPIN-1:0]   clkRise;
  wire [1:0]               ceIn;
  wire [1:0]               ceOut;
  wire [1:0]               clrIn;
  wire [1:0]               clrOut;
  wire [1:0]               wrenIn;
  wire [1:0]               rdenIn;
  wire [2*`DPRCM_AW-1:0]   addrIn;
  wire [2*`DPRCM_DW-1:0]   dataIn;
  wire [2*`DPRCM_BW-1:0]   beIn;
  wire [1:0]               memWe;
  wire [2*`DPRCM_AW-1:0]   memAddr;
  wire [2*`DPRCM_DW-1:0]   memWd;
  wire [2*`DPRCM_BW-1:0]   memBe;
  wire [2*`DPRCM_DW-1:0]   memRd;
  wire [2*`DPRCM_DW-1:0]   doutBus;
  wire                     ioMode;
  wire                     rwMode;
  wire                     sdp;
  wire                     split;

  assign clkPins = {clkOutB, clkB, clkOutA, clkA};
  assign ceIn    = {ceInB, ceInA};
  assign ceOut   = {ceOutB, ceOutA};
  assign clrIn   = {clrInB, clrInA};
  assign clrOut  = {clrOutB, clrOutA};
  assign wrenIn  = {wrenB, wrenA};
  assign rdenIn  = {rdenB, `DPRCM_BIT_CLR};
  assign addrIn  = {addrB, addrA};
  assign dataIn  = {dataInB, dataInA};
  assign beIn    = {byteEnB, byteEnA};

  assign ioMode = (mode == `DPRCM_MODE_IOCLK);
  assign rwMode = (mode == `DPRCM_MODE_RWCLK);
  assign sdp    = rwMode | (ioMode & simpleDual);
  assign split  = (mode == `DPRCM_MODE_SINGLE) & splitSingle;

  // port clocks come from fabric pins, so each is synchronised before
  // its rising edge is used; they must run well below mclk
  // stages reset high: a pin already high at release is not an edge
  genvar i;
  generate
    for (i = 0; i < `DPRCM_NPIN; i = i + 1) begin : gSync
      reg s1;
      reg s2;
      reg s3;
      always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          s1 <= `DPRCM_BIT_SET;
          s2 <= `DPRCM_BIT_SET;
          s3 <= `DPRCM_BIT_SET;
        end else begin
          s1 <= clkPins[i];
          s2 <= s1;
          s3 <= s2;
        end
      end
      assign clkRise[i] = s2 & ~s3;
    end
  endgenerate

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : gPort
      reg  [`DPRCM_AW-1:0] addrReg;
      reg  [`DPRCM_DW-1:0] dataReg;
      reg  [`DPRCM_BW-1:0] beReg;
      reg                  wrenReg;
      reg                  rdenReg;
      reg                  wrGo;
      reg  [`DPRCM_DW-1:0] dout;
      wire                 inEdge;
      wire                 outEdge;
      wire                 outCe;
      wire                 inClrN;
      wire                 outClrN;
      wire                 canWrite;
      wire                 readQual;
      wire                 capture;
      reg  [1:0]           inRel;
      reg  [1:0]           outRel;
      wire                 inRawN;
      wire                 outRawN;

      assign inEdge  = clkRise[2*p];
      // only io mode hands the output register to the second clock
      assign outEdge = ioMode ? clkRise[2*p+1] : clkRise[2*p];
      assign outCe   = ioMode ? ceOut[p] : ceIn[p];
      assign inRawN  = reset_n & ~clrIn[p];
      assign outRawN = reset_n & ~(ioMode ? clrOut[p] : clrIn[p]);
      // clears bite at once but let go only on an mclk edge, so no
      // register leaves its cleared state right at a capturing edge
      always @(posedge mclk or negedge inRawN) begin
        if (!inRawN) begin
          inRel <= `DPRCM_REL_CLR;
        end else begin
          inRel <= {inRel[0], `DPRCM_BIT_SET};
        end
      end
      always @(posedge mclk or negedge outRawN) begin
        if (!outRawN) begin
          outRel <= `DPRCM_REL_CLR;
        end else begin
          outRel <= {outRel[0], `DPRCM_BIT_SET};
        end
      end
      assign inClrN  = inRel[1];
      assign outClrN = outRel[1];
      assign capture = inEdge & ceIn[p];
      // simple dual-port: a writes, b reads
      assign canWrite = sdp ? (p == 0) : 1'b1;
      // true dual and single-port: wren alone picks read or write
      assign readQual = sdp ? rdenReg : ~wrenReg;

      always @(posedge mclk or negedge inClrN) begin
        if (!inClrN) begin
          addrReg <= `DPRCM_ADDR_CLR;
          dataReg <= `DPRCM_DATA_CLR;
          beReg   <= `DPRCM_BE_CLR;
          wrenReg <= `DPRCM_BIT_CLR;
          wrGo    <= `DPRCM_BIT_CLR;
        end else begin
          wrGo <= capture & wrenIn[p] & canWrite;
          if (capture) begin
            addrReg <= addrIn[p*`DPRCM_AW +: `DPRCM_AW];
            dataReg <= dataIn[p*`DPRCM_DW +: `DPRCM_DW];
            beReg   <= beIn[p*`DPRCM_BW +: `DPRCM_BW];
            wrenReg <= wrenIn[p];
          end
        end
      end

      // read enable keeps only a synchronous power-on reset
      always @(posedge mclk) begin
        if (!reset_n) begin
          rdenReg <= `DPRCM_BIT_CLR;
        end else if (capture) begin
          rdenReg <= rdenIn[p] & (p == 1);
        end
      end

      always @(posedge mclk or negedge outClrN) begin
        if (!outClrN) begin
          dout <= `DPRCM_DATA_CLR;
        end else if (outEdge && outCe && readQual) begin
          dout <= memRd[p*`DPRCM_DW +: `DPRCM_DW];
        end
      end

      assign memWe[p] = wrGo;
      // lane mask is the captured byte enable, so a write lands only in enabled lanes
      assign memBe[p*`DPRCM_BW +: `DPRCM_BW] = beReg;
      assign memWd[p*`DPRCM_DW +: `DPRCM_DW] = dataReg;
      // split single-port: each port owns one 2K-bit half
      assign memAddr[p*`DPRCM_AW +: `DPRCM_AW] =
        {split ? (p == 1) : addrReg[`DPRCM_AW-1],
         addrReg[`DPRCM_AW-2:0]};
      assign doutBus[p*`DPRCM_DW +: `DPRCM_DW] = dout;
    end
  endgenerate

  assign dataOutA = doutBus[`DPRCM_DW-1:0];
  assign dataOutB = doutBus[2*`DPRCM_DW-1:`DPRCM_DW];

  dprcm_mem uMem (
    .mclk  (mclk),
    .weA   (memWe[0]),
    .beA   (memBe[`DPRCM_BW-1:0]),
    .addrA (memAddr[`DPRCM_AW-1:0]),
    .wdA   (memWd[`DPRCM_DW-1:0]),
    .rdA   (memRd[`DPRCM_DW-1:0]),
    .weB   (memWe[1]),
    .beB   (memBe[2*`DPRCM_BW-1:`DPRCM_BW]),
    .addrB (memAddr[2*`DPRCM_AW-1:`DPRCM_AW]),
    .wdB   (memWd[2*`DPRCM_DW-1:`DPRCM_DW]),
    .rdB   (memRd[2*`DPRCM_DW-1:`DPRCM_DW])
  );
endmodule
`default_nettype wire

// ---- tb/dprcm_fabric.sv ----
// fabric-side model: one port clock pulse per request
`timescale 1ns/1ps
`default_nettype none
module dprcm_fabric (
  input  wire logic mclk,
  input  wire logic go,
  output wire logic pin
);
  logic [3:0] n = 4'h0;
  always @(posedge mclk) n <= (go && n == 4'h0) ? 4'h8 : n - (n != 4'h0);
  // four high, four low; bench holds port inputs for the whole pulse
  assign pin = n > 4'h4;
endmodule
`default_nettype wire

// ---- tb/dprcm_core_assertions.sv ----
// concurrent checks on the output registers of the ram block
`timescale 1ns/1ps
`default_nettype none
module dprcm_core_assertions (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [1:0]  mode,
  input wire logic        clkA,
  input wire logic        clkB,
  input wire logic        ceInB,
  input wire logic        ceOutA,
  input wire logic        clrInA,
  input wire logic        clrInB,
  input wire logic        clrOutA,
  input wire logic [15:0] dataOutA,
  input wire logic [15:0] dataOutB
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // five low samples: any earlier pin edge is already consumed
  sequence s_quietA; !clkA [*5]; endsequence
  sequence s_quietB; !clkB [*5]; endsequence
  a_reset_zero: assert property (disable iff (1'b0) !reset_n |->
    dataOutA == 16'h0000 && dataOutB == 16'h0000) else $error("reset");
  a_clear_ina: assert property (mode != 2'h1 && clrInA |->
    dataOutA == 16'h0000) else $error("clear A");
  a_clear_inb: assert property (mode != 2'h1 && clrInB |->
    dataOutB == 16'h0000) else $error("clear B");
  a_clear_outa: assert property (mode == 2'h1 && clrOutA |->
    dataOutA == 16'h0000) else $error("out clear A");
  a_ce_hold: assert property (mode != 2'h1 && !ceInB && !clrInB
    ##1 !clrInB |-> $stable(dataOutB)) else $error("ce hold B");
  a_ceout_hold: assert property (mode == 2'h1 && !ceOutA && !clrOutA
    ##1 !clrOutA |-> $stable(dataOutA)) else $error("ce out A");
  a_quiet_a: assert property (s_quietA ##0 mode != 2'h1 && !clrInA
    ##1 !clrInA |-> $stable(dataOutA)) else $error("quiet A");
  a_quiet_b: assert property (s_quietB ##0 mode != 2'h1 && !clrInB
    ##1 !clrInB |-> $stable(dataOutB)) else $error("quiet B");
endmodule
`default_nettype wire

// ---- tb/dprcm_core_tb.sv ----
// self-checking bench for the clock-mode ram block
`timescale 1ns/1ps
`default_nettype none
module dprcm_core_tb;
  logic        mclk, reset_n, simpleDual, splitSingle, clkA, clkB, clkOutA;
  logic        clkOutB, ceInA, ceInB, ceOutA, ceOutB, clrInA, clrInB;
  logic        clrOutA, clrOutB, wrenA, wrenB, rdenB;
  logic [1:0]  mode, byteEnA, byteEnB;
  logic [3:0]  go;
  logic [7:0]  addrA, addrB;
  logic [15:0] dataInA, dataInB, dataOutA, dataOutB, r;
  logic [15:0] mem [256];
  int          mismatches, samples_checked;
  dprcm_core dut (
    .mclk(mclk), .reset_n(reset_n), .mode(mode),
    .simpleDual(simpleDual), .splitSingle(splitSingle),
    .clkA(clkA), .clkOutA(clkOutA), .ceInA(ceInA), .ceOutA(ceOutA),
    .clrInA(clrInA), .clrOutA(clrOutA), .addrA(addrA),
    .dataInA(dataInA), .wrenA(wrenA), .byteEnA(byteEnA),
    .dataOutA(dataOutA),
    .clkB(clkB), .clkOutB(clkOutB), .ceInB(ceInB), .ceOutB(ceOutB),
    .clrInB(clrInB), .clrOutB(clrOutB), .addrB(addrB),
    .dataInB(dataInB), .wrenB(wrenB), .byteEnB(byteEnB),
    .rdenB(rdenB), .dataOutB(dataOutB)
  );
  dprcm_fabric fa (.mclk(mclk), .go(go[0]), .pin(clkA));
  dprcm_fabric fb (.mclk(mclk), .go(go[1]), .pin(clkB));
  dprcm_fabric fo (.mclk(mclk), .go(go[2]), .pin(clkOutA));
  dprcm_fabric fob (.mclk(mclk), .go(go[3]), .pin(clkOutB));
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] mrg(input logic [15:0] o, d,
                                      input logic [1:0] be);
    return {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]};
  endfunction
  function automatic logic [7:0] ix(input logic b, input logic [7:0] a);
    return (mode == 2'h3 && splitSingle) ? {b, a[6:0]} : a;
  endfunction
  task automatic cmp(input logic [15:0] got, e);
    samples_checked++;
    if (got !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, e);
    end
  endtask
  task automatic ev(input logic [3:0] g);
    @(posedge mclk) #5 go = g;
    @(posedge mclk) #5 go = 4'h0;
    repeat (12) @(posedge mclk);
    #5;
  endtask
  task automatic put(input logic b, w, input logic [7:0] a,
                     input logic [15:0] d, input logic [1:0] be);
    if (b) {wrenB, addrB, dataInB, byteEnB} = {w, a, d, be};
    else {wrenA, addrA, dataInA, byteEnA} = {w, a, d, be};
    ev(b ? 4'h2 : 4'h1);
  endtask
  task automatic wr(input logic b, input logic [7:0] a,
                    input logic [15:0] d, input logic [1:0] be);
    put(b, 1'b1, a, d, be);
    // port B never writes in simple dual-port
    if (!(b && (mode == 2'h2 || (mode == 2'h1 && simpleDual))))
      mem[ix(b, a)] = mrg(mem[ix(b, a)], d, be);
  endtask
  task automatic rd(input logic b, input logic [7:0] a, input logic [15:0] e);
    put(b, 1'b0, a, 16'h0000, 2'h0);
    put(b, 1'b0, a, 16'h0000, 2'h0);
    cmp(b ? dataOutB : dataOutA, e);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (4000) @(posedge mclk);
    mismatches++;
    close_out;
  end
  initial begin
    {reset_n, simpleDual, splitSingle, ceOutB, clrOutB} = '0;
    {clrInA, clrInB, clrOutA, wrenA, wrenB, rdenB, go, mode} = '0;
    {ceInA, ceInB, ceOutA, r} = {3'h7, 16'h0039};
    {addrA, addrB, dataInA, dataInB, byteEnA, byteEnB} = '0;
    repeat (6) @(posedge mclk);
    #5 reset_n = 1;
    for (int i = 0; i < 16; i++) begin
      r = lf(r);
      wr(i[0], i[7:0], r, 2'h3);
    end
    for (int i = 0; i < 12; i++) begin
      r = lf(r);
      wr(r[0], {4'h0, r[11:8]}, ~r, i < 3 ? 2'h3 : r[2:1]);
      rd(!r[0], {4'h0, r[11:8]}, mem[{4'h0, r[11:8]}]);
    end
    rd(1'b1, 8'h01, mem[8'h01]);
    ceInB = 0;
    rd(1'b1, 8'h02, mem[8'h01]);
    {ceInB, clrInA, clrInB} = 3'h7;
    #100 cmp(dataOutA | dataOutB, 16'h0000);
    {clrInA, clrInB, mode, clrOutA} = 5'h03;
    $display("independent clock test done");
    #100 clrOutA = 0;
    put(1'b0, 1'b0, 8'h04, 16'h0000, 2'h0);
    put(1'b0, 1'b0, 8'h04, 16'h0000, 2'h0);
    cmp(dataOutA, 16'h0000);
    ceOutA = 0;
    ev(4'h4);
    cmp(dataOutA, 16'h0000);
    ceOutA = 1;
    ev(4'h4);
    cmp(dataOutA, mem[8'h04]);
    // simple dual-port under io clocks: a writes, b reads via clkOutB
    {simpleDual, rdenB, ceOutB} = 3'h7;
    wr(1'b0, 8'h0a, r, 2'h3);
    wr(1'b1, 8'h0a, ~r, 2'h3);
    put(1'b1, 1'b0, 8'h0a, 16'h0000, 2'h0);
    ev(4'hc);
    cmp(dataOutA, mem[8'h04]);
    cmp(dataOutB, mem[8'h0a]);
    $display("io clock test done");
    {mode, rdenB} = 3'h5;
    wr(1'b0, 8'h07, r, 2'h3);
    wr(1'b1, 8'h07, ~r, 2'h3);
    rd(1'b1, 8'h07, mem[8'h07]);
    rdenB = 0;
    rd(1'b1, 8'h08, mem[8'h07]);
    // read enable must survive the read-side clear
    rdenB = 1;
    put(1'b1, 1'b0, 8'h07, 16'h0000, 2'h0);
    clrInB = 1;
    #100 {clrInB, rdenB} = 2'h0;
    cmp(dataOutB, 16'h0000);
    put(1'b1, 1'b0, 8'h08, 16'h0000, 2'h0);
    cmp(dataOutB, mem[8'h00]);
    $display("read write clock test done");
    {mode, splitSingle} = 3'h7;
    wr(1'b0, 8'h09, r, 2'h3);
    wr(1'b1, 8'h09, ~r, 2'h3);
    rd(1'b0, 8'h09, mem[ix(1'b0, 8'h09)]);
    rd(1'b1, 8'h09, mem[ix(1'b1, 8'h09)]);
    $display("single port test done");
    close_out;
  end
endmodule
bind dprcm_core dprcm_core_assertions chk (
  .mclk(mclk), .reset_n(reset_n), .mode(mode), .clkA(clkA),
  .clkB(clkB), .ceInB(ceInB), .ceOutA(ceOutA), .clrInA(clrInA),
  .clrInB(clrInB), .clrOutA(clrOutA), .dataOutA(dataOutA),
  .dataOutB(dataOutB)
);
`default_nettype wire
